/* hdl/srlc_top.sv */
// set-reset latch with software, pin, comparator and divided-clock sources
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "srlc_cfg.svh"
//
// Behaviour
// [RQ1] master enable bit 7 turns latch on; cleared, output enables do nothing
// [RQ2] divider field picks one-cycle pulse every 4 to 512 oscillator cycles
// [RQ3] enabled latch with true-output enable drives latch state to true pin
// [RQ4] enabled latch with inverted enable drives complemented state to inverted pin
// [RQ5] writing 1 to software set pulses set input for exactly one cycle
// [RQ6] writing 1 to software reset pulses reset input for exactly one cycle
// [RQ7] software set and reset bits self-clear and always read zero
// [RQ8] pin-set enable lets high input pin set the latch
// [RQ9] clock-set enable applies each divider pulse to the set input
// [RQ10] comparator-set enable lets high comparator result set the latch
// [RQ11] pin-reset enable lets high input pin reset the latch
// [RQ12] clock-reset enable applies each divider pulse to the reset input
// [RQ13] comparator-reset enable lets high comparator result reset the latch
// [RQ14] software keeps reserved source bits clear; they read as zero
// [RQ15] reset dominates when set and reset are both asserted
// [RQ16] set and reset inputs active high; latch holds state between events
// [RQ17] latch state undefined after reset; software initialises before enabling pins
// [RQ18] effective set/reset is OR of enabled set/reset sources
// [RQ19] divider free-runs and follows divider field changes immediately
module srlc_top #(
  parameter int DIV_WIDTH = `SRLC_DIV_WIDTH
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_wb_cyc,
  input  wire logic       i_wb_stb,
  input  wire logic       i_wb_we,
  input  wire logic [3:0] i_wb_adr,
  input  wire logic [3:0] i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_latch_input_pin,
  input  wire logic        i_comparator_result,
  output logic             o_true_output_pin,
  output logic             o_true_output_oe,
  output logic             o_inverted_output_pin,
  output logic             o_inverted_output_oe
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (DIV_WIDTH < `SRLC_DIV_WIDTH) begin : g_bad_width
    $error("divider too narrow for the 512-cycle period");
  end

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [1:0] pin_sync;
  logic [1:0] cmp_sync;
  logic [1:0] next_pin_sync;
  logic [1:0] next_cmp_sync;
  logic       pin_level;
  logic       cmp_level;

  // two stages; only stage two is read by logic
  always_comb begin
    next_pin_sync = {pin_sync[0], i_latch_input_pin};
    next_cmp_sync = {cmp_sync[0], i_comparator_result};
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_sync <= 2'h0;
      cmp_sync <= 2'h0;
    end else begin
      pin_sync <= next_pin_sync;
      cmp_sync <= next_cmp_sync;
    end
  end

  assign pin_level = pin_sync[1];
  assign cmp_level = cmp_sync[1];

  // ***************************************************************
  // register bus slave
  // ***************************************************************
  srlc_pkg::srlc_bus_type bus_state;
  srlc_pkg::srlc_bus_type next_bus_state;
  logic [7:0] control_primary;
  logic [7:0] source_select;
  logic [7:0] next_control_primary;
  logic [7:0] next_source_select;
  logic       sw_set;
  logic       sw_reset;
  logic       next_sw_set;
  logic       next_sw_reset;
  logic [31:0] next_rdata;
  logic [31:0] rdata;
  logic        latch_q;
  logic        wr_lane0;

  // request taken on first cycle of cyc&stb, answered one cycle later
  assign wr_lane0 = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0]
                    & (bus_state == srlc_pkg::SRLC_BUS_IDLE);

  // register writes and software pulse generation
  always_comb begin
    next_control_primary = control_primary;
    next_source_select   = source_select;
    next_rdata           = 32'h0000_0000;
    next_bus_state       = srlc_pkg::SRLC_BUS_IDLE;
    // [RQ5] [RQ6] [RQ7] pulse bits last one cycle
    next_sw_set          = 1'b0;
    next_sw_reset        = 1'b0;
    case (bus_state)
      srlc_pkg::SRLC_BUS_IDLE: begin
        if (i_wb_cyc && i_wb_stb) begin
          next_bus_state = srlc_pkg::SRLC_BUS_ACK;
          case (i_wb_adr)
            `SRLC_OFS_CONTROL_PRIMARY: begin
              // [RQ7] pulse bits read as zero
              next_rdata = {24'h00_0000, control_primary[7:2], 2'h0};
              if (wr_lane0) begin
                next_control_primary = {i_wb_dat[7:2], 2'h0};
                // [RQ5] write 1 sets only
                next_sw_set   = i_wb_dat[`SRLC_BIT_SW_SET];
                // [RQ6] write 1 resets only
                next_sw_reset = i_wb_dat[`SRLC_BIT_SW_RESET];
              end
            end
            `SRLC_OFS_SOURCE_SELECT: begin
              next_rdata = {24'h00_0000, source_select};
              // [RQ14] reserved bits never stored, read zero
              if (wr_lane0) begin
                next_source_select = i_wb_dat[7:0] & `SRLC_SOURCE_WMASK;
              end
            end
            `SRLC_OFS_STATUS: begin
              next_rdata = {31'h0000_0000, latch_q};
            end
            default: begin
              next_rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      srlc_pkg::SRLC_BUS_ACK: begin
        next_bus_state = srlc_pkg::SRLC_BUS_IDLE;
      end
      default: begin
        next_bus_state = srlc_pkg::SRLC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      bus_state       <= srlc_pkg::SRLC_BUS_IDLE;
      control_primary <= `SRLC_RESET_PRIMARY;
      source_select   <= `SRLC_RESET_SOURCE;
      sw_set          <= 1'b0;
      sw_reset        <= 1'b0;
      rdata           <= 32'h0000_0000;
    end else begin
      bus_state       <= next_bus_state;
      control_primary <= next_control_primary;
      source_select   <= next_source_select;
      sw_set          <= next_sw_set;
      sw_reset        <= next_sw_reset;
      rdata           <= next_rdata;
    end
  end

  assign o_wb_ack = (bus_state == srlc_pkg::SRLC_BUS_ACK);
  assign o_wb_dat = rdata;

  // ***************************************************************
  // periodic pulse divider
  // ***************************************************************
  logic [DIV_WIDTH-1:0] div_count;
  logic [DIV_WIDTH-1:0] next_div_count;
  logic                 div_pulse;

  // period mask for a divider code: 2^(code+2)-1
  function automatic logic [DIV_WIDTH-1:0] srlc_period_mask(input logic [2:0] code);
    logic [DIV_WIDTH:0] one_hot;
    one_hot = '0;
    one_hot[`SRLC_DIV_BASE_SHIFT + code] = 1'b1;
    return DIV_WIDTH'(one_hot - 1'b1);
  endfunction

  // [RQ19] free-running counter, new period takes effect at once
  always_comb begin
    next_div_count = div_count + 1'b1;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      div_count <= '0;
    end else begin
      div_count <= next_div_count;
    end
  end

  // [RQ2] one cycle every 2^(code+2) cycles
  assign div_pulse = ((div_count & srlc_period_mask(
                       control_primary[`SRLC_DIV_HI:`SRLC_DIV_LO])) == '0);

  // ***************************************************************
  // source gating and latch
  // ***************************************************************
  logic set_in;
  logic reset_in;
  logic next_latch_q;
  logic next_latch_nq;
  logic latch_nq;
  logic enabled;

  // [RQ18] OR of enabled sources; [RQ8] [RQ9] [RQ10] set side
  assign set_in = sw_set
                | (source_select[`SRLC_BIT_PIN_SET] & pin_level)
                | (source_select[`SRLC_BIT_CLK_SET] & div_pulse)
                | (source_select[`SRLC_BIT_CMP_SET] & cmp_level);
  // [RQ11] [RQ12] [RQ13] reset side
  assign reset_in = sw_reset
                  | (source_select[`SRLC_BIT_PIN_RESET] & pin_level)
                  | (source_select[`SRLC_BIT_CLK_RESET] & div_pulse)
                  | (source_select[`SRLC_BIT_CMP_RESET] & cmp_level);

  // [RQ15] [RQ16] reset dominant, holds otherwise
  always_comb begin
    next_latch_q = latch_q;
    if (reset_in) begin
      next_latch_q = 1'b0;
    end else if (set_in) begin
      next_latch_q = 1'b1;
    end
    // own flop for the inverted pin, so no gate sits on an output
    next_latch_nq = ~next_latch_q;
  end

  // latch state is architecturally unknown after reset; zero chosen
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      latch_q  <= 1'b0;
      latch_nq <= 1'b1;
    end else begin
      latch_q  <= next_latch_q;
      latch_nq <= next_latch_nq;
    end
  end

  // [RQ1] master enable gates both output enables
  assign enabled = control_primary[`SRLC_BIT_MASTER_ENABLE];
  // [RQ3] true output
  assign o_true_output_oe  = enabled & control_primary[`SRLC_BIT_TRUE_OE];
  assign o_true_output_pin = latch_q;
  // [RQ4] inverted output
  assign o_inverted_output_oe  = enabled & control_primary[`SRLC_BIT_INV_OE];
  assign o_inverted_output_pin = latch_nq;

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence s_sw_write;
    wr_lane0 && (i_wb_adr == `SRLC_OFS_CONTROL_PRIMARY);
  endsequence

  a_sw_set_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ5]
    s_sw_write and i_wb_dat[1] |=> sw_set ##1 !sw_set)
    else $error("software set pulse not one cycle");

  a_sw_reset_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ6]
    s_sw_write and i_wb_dat[0] |=> sw_reset ##1 !sw_reset)
    else $error("software reset pulse not one cycle");

  a_pulse_read_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ7]
    o_wb_ack && $past(i_wb_adr) == `SRLC_OFS_CONTROL_PRIMARY |-> o_wb_dat[1:0] == 2'h0)
    else $error("pulse bits read nonzero");

  a_reset_wins: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ15]
    reset_in |=> !latch_q)
    else $error("latch not reset");

  a_set_works: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ18]
    set_in && !reset_in |=> latch_q)
    else $error("latch not set");

  a_latch_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ16]
    !set_in && !reset_in |=> $stable(latch_q))
    else $error("latch changed without input");

  a_disable_outputs: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ1]
    !enabled |-> !o_true_output_oe && !o_inverted_output_oe)
    else $error("output enabled while latch disabled");

  // pulse at code 0, then four cycles that keep code 0; a code change may shift phase
  sequence s_code0_window;
    div_pulse && (control_primary[`SRLC_DIV_HI:`SRLC_DIV_LO] == 3'h0)
      ##1 (control_primary[`SRLC_DIV_HI:`SRLC_DIV_LO] == 3'h0) [*4];
  endsequence

  a_div_min_period: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ2]
    s_code0_window |-> div_pulse && !$past(div_pulse, 1) && !$past(div_pulse, 2)
      && !$past(div_pulse, 3))
    else $error("divider code 0 period not 4");

  a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ14]
    source_select[5] == 1'b0 && source_select[1] == 1'b0)
    else $error("reserved source bit stored");

  a_comp_set: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RQ10]
    source_select[4] && cmp_level |-> set_in)
    else $error("comparator set not applied");

endmodule

/* shared/srlc_cfg.svh */
// constants of the set-reset latch control block: offsets, fields, resets, timing
`ifndef SRLC_CFG_SVH
`define SRLC_CFG_SVH
// ***************************************************************
// register byte offsets
// ***************************************************************
`define SRLC_OFS_CONTROL_PRIMARY 4'h0
`define SRLC_OFS_SOURCE_SELECT   4'h4
`define SRLC_OFS_STATUS          4'h8
// ***************************************************************
// latch_control_primary fields
// ***************************************************************
`define SRLC_BIT_MASTER_ENABLE   7
`define SRLC_DIV_HI              6
`define SRLC_DIV_LO              4
`define SRLC_BIT_TRUE_OE         3
`define SRLC_BIT_INV_OE          2
`define SRLC_BIT_SW_SET          1
`define SRLC_BIT_SW_RESET        0
// ***************************************************************
// latch_source_select fields
// ***************************************************************
`define SRLC_BIT_PIN_SET         7
`define SRLC_BIT_CLK_SET         6
`define SRLC_BIT_RSVD_HI         5
`define SRLC_BIT_CMP_SET         4
`define SRLC_BIT_PIN_RESET       3
`define SRLC_BIT_CLK_RESET       2
`define SRLC_BIT_RSVD_LO         1
`define SRLC_BIT_CMP_RESET       0
// writable mask of the source register, reserved bits held at zero
`define SRLC_SOURCE_WMASK        8'hDD
// ***************************************************************
// reset values and timing
// ***************************************************************
`define SRLC_RESET_PRIMARY       8'h00
`define SRLC_RESET_SOURCE        8'h00
// shortest divider period is 4 oscillator cycles, i.e. shift of 2
`define SRLC_DIV_BASE_SHIFT      2
`define SRLC_DIV_WIDTH           9
`endif

/* shared/srlc_pkg.sv */
// types of the set-reset latch control block
package srlc_pkg;
  // bus slave phase
  typedef enum logic [0:0] {
    SRLC_BUS_IDLE,
    SRLC_BUS_ACK
  } srlc_bus_type;
endpackage

/* testbench/srlc_far_side.sv */
// far-side model: input pin, comparator result and pulled-down output line
`timescale 1ns/1ps
module srlc_far_side (
  input  wire logic i_clk,
  input  wire logic i_pin_req,
  input  wire logic i_cmp_req,
  input  wire logic i_q,
  input  wire logic i_q_oe,
  output logic      o_pin = 1'b0,
  output logic      o_cmp = 1'b0,
  output logic      o_q_line
);
  // levels move only just after an edge, like a clocked source
  always @(posedge i_clk) begin
    o_pin <= i_pin_req;
    o_cmp <= i_cmp_req;
  end
  // a released output line falls to its pull-down, not the last value
  assign o_q_line = i_q_oe ? i_q : 1'b0;
endmodule

/* testbench/tb_top.sv */
// self-checking bench of the set-reset latch control block
`timescale 1ns/1ps
`include "srlc_cfg.svh"
module tb_top;
  localparam logic [3:0] CTL = `SRLC_OFS_CONTROL_PRIMARY;
  localparam logic [3:0] SRC = `SRLC_OFS_SOURCE_SELECT;
  localparam logic [7:0] SRCS [8] = '{8'h80, 8'h08, 8'h10, 8'h01, 8'h88, 8'h00, 8'h01, 8'h80};
  localparam logic [7:0] USE_CMP = 8'hAC;
  localparam logic [7:0] PRE     = 8'h7A;
  localparam logic [7:0] EXP     = 8'h65;
  logic        clk, rst, cyc, stb, we, pin_req, cmp_req;
  logic        q_prev = 1'b0;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, rd;
  logic        ack, pin, cmp, q, q_oe, nq, nq_oe, q_line;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  int          rise_t = 0;
  int          n_rise = 0;
  int          lat_m, ctrl_m, n, i, k;
  int          tr [2];

  srlc_top i_dut (
    .i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_latch_input_pin(pin), .i_comparator_result(cmp), .o_true_output_pin(q),
    .o_true_output_oe(q_oe), .o_inverted_output_pin(nq), .o_inverted_output_oe(nq_oe));
  srlc_far_side i_far (
    .i_clk(clk), .i_pin_req(pin_req), .i_cmp_req(cmp_req), .i_q(q), .i_q_oe(q_oe),
    .o_pin(pin), .o_cmp(cmp), .o_q_line(q_line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cycle stamp of each rising edge of the true output
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    q_prev <= q;
    if (q === 1'b1 && q_prev === 1'b0) begin
      rise_t <= cyc_cnt;
      n_rise <= n_rise + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      c++;
    end while (ack !== 1'b1 && c < 20);
    rd = rdat;
    {cyc, stb, we} <= 3'h0;
    if (c >= 20) begin
      failures++;
      finish_test();
    end
  endtask

  initial begin
    {cyc, stb, we, adr, wdat, pin_req, cmp_req} = '0;
    sel = 4'hF;
    rst = 1'b1;
    k = $urandom(32'h545A);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(0, CTL, 0); chk(rd, 0);
    wb(0, SRC, 0); chk(rd, 0);
    // state is unknown after reset, so clear it first
    wb(1, CTL, 32'h01);
    lat_m = 0;
    // random control words; the last two leave the latch off
    for (i = 0; i < 12; i++) begin
      ctrl_m = (i < 10) ? ($urandom & 8'hFF) | 8'h80 : $urandom & 8'h7C;
      wb(1, CTL, 32'(ctrl_m));
      if (ctrl_m[0]) lat_m = 0;
      else if (ctrl_m[1]) lat_m = 1;
      #1;
      chk(32'(q_oe), 32'(ctrl_m[7] & ctrl_m[3]));
      chk(32'(nq_oe), 32'(ctrl_m[7] & ctrl_m[2]));
      chk(32'(q), 32'(lat_m));
      chk(32'(nq), 32'(!lat_m));
      chk(32'(q_line), 32'(ctrl_m[7] & ctrl_m[3] & lat_m));
      wb(0, CTL, 0); chk(rd, 32'(ctrl_m & 8'hFC));
      wb(0, `SRLC_OFS_STATUS, 0); chk(rd, 32'(lat_m));
    end
    // a write without byte lane 0 must leave control word and latch alone
    sel <= 4'hE;
    wb(1, CTL, 32'h8E);
    sel <= 4'hF;
    wb(0, CTL, 0); chk(rd, 32'(ctrl_m & 8'hFC));
    wb(0, `SRLC_OFS_STATUS, 0); chk(rd, 32'(lat_m));
    // software keeps the reserved source bits clear
    wb(1, SRC, 32'hDD); wb(0, SRC, 0); chk(rd, 32'hDD);
    wb(1, 4'hC, 32'h5A); wb(0, 4'hC, 0); chk(rd, 0);
    // pin and comparator sources, each enabled and not enabled
    for (i = 0; i < 8; i++) begin
      wb(1, SRC, 0);
      wb(1, CTL, PRE[i] ? 32'h82 : 32'h81);
      wb(1, SRC, 32'(SRCS[i]));
      {pin_req, cmp_req} <= USE_CMP[i] ? 2'h1 : 2'h2;
      repeat (7) @(posedge clk);
      #1; chk(32'(q), 32'(EXP[i]));
      @(posedge clk);
      {pin_req, cmp_req} <= 2'h0;
    end
    // divider pulse sets the latch again after each software clear
    wb(1, SRC, 32'h40);
    for (i = 0; i < 8; i++) begin
      wb(1, CTL, 32'h80 | (i << 4));
      for (k = 0; k < 2; k++) begin
        wb(1, CTL, 32'h81 | (i << 4));
        n = 0;
        ctrl_m = n_rise;
        while (n_rise == ctrl_m && n < 600) begin
          @(posedge clk);
          n++;
        end
        chk(32'(n <= (4 << i) + 3), 1);
        if (n >= 600) finish_test();
        tr[k] = rise_t;
      end
      chk(32'((tr[1] - tr[0]) % (4 << i)), 0);
    end
    // divider pulse on the reset side clears a set latch
    wb(1, SRC, 32'h04);
    wb(1, CTL, 32'h82);
    n = 0;
    while (q !== 1'b0 && n < 16) begin
      @(posedge clk);
      n++;
    end
    #1; chk(32'(q), 0);
    finish_test();
  end
endmodule
